// ---- rtl/rss_defs.svh ----
// constants for the reset source sequencer
// assumes a 25 MHz system clock
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
`define RSS_CLK_KHZ        25000
`define RSS_POR_DLY_LO_US  3000
`define RSS_POR_DLY_MID_US 7000
`define RSS_POR_DLY_HI_US  15000
`define RSS_POR_CYC(us)    (((us) * `RSS_CLK_KHZ) / 1000)
`define RSS_WDT_DIV        4'hb
`define RSS_PORT_RST       8'hff
`define RSS_PC_RST         16'h0000
`define RSS_SYNC_W         3
`endif

// ---- rtl/rss_pkg.sv ----
// types for the reset source sequencer
// assumes rss_defs.svh holds the numeric constants
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_ST_HOLD    = 2'b00,
    RSS_ST_PORWAIT = 2'b01,
    RSS_ST_RUN     = 2'b10
  } rss_state_t;
  typedef enum logic [1:0] {
    RSS_LVL_LOW  = 2'b00,
    RSS_LVL_MID  = 2'b01,
    RSS_LVL_HIGH = 2'b10
  } rss_level_t;
  typedef struct packed {
    logic supply_monitor_enable;
    logic monitor_select;
  } rss_mon_cfg_t;
  typedef struct packed {
    logic        core_rst;
    logic        rst_pin_oe;
    logic [7:0]  port_latch;
    logic        pullup_en;
    logic        irq_tmr_dis;
    logic        sp_rst;
    logic [15:0] pc_load;
    logic        int_osc_sel;
    logic        wdt_run;
  } rss_core_ctl_t;
endpackage

// ---- rtl/rss_reset_source_sequencer.sv ----
// reset source sequencer: holds core in reset, drives reset pin, por delay, cause flag
// assumes analog comparator levels asynchronous, software strobes on clk
`include "rss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  bat_above_por,
  input  wire logic                  vdd_above_fail,
  input  wire logic                  vdd_above_warn,
  input  wire rss_pkg::rss_level_t   bat_level,
  input  wire logic                  sleep_mode,
  input  wire logic                  other_rst_req,
  input  wire logic                  flash_op_req,
  input  wire logic                  cause_wr,
  input  wire logic                  cause_wr_poweron_bit,
  input  wire logic                  mon_ctl_wr,
  input  wire logic                  mon_ctl_wr_enable,
  input  wire logic                  mode_wr,
  input  wire logic                  mode_wr_battery_monitor_disable,
  input  wire logic                  early_ok_ie,
  output logic                       rst_pin_o,
  output logic                       rst_pin_oe,
  output rss_pkg::rss_core_ctl_t     core_ctl,
  output logic                       wdt_tick,
  output logic                       poweron_flag,
  output rss_pkg::rss_mon_cfg_t      mon_cfg,
  output logic                       battery_monitor_disable,
  output logic                       supply_early_ok,
  output logic                       early_warn_irq,
  output logic                       flash_op_ok,
  output logic                       flash_error_rst
);
  localparam int unsigned CYC_LO  = `RSS_POR_CYC(`RSS_POR_DLY_LO_US);
  localparam int unsigned CYC_MID = `RSS_POR_CYC(`RSS_POR_DLY_MID_US);
  localparam int unsigned CYC_HI  = `RSS_POR_CYC(`RSS_POR_DLY_HI_US);

  // three-stage synchronisers for analog levels
  logic [`RSS_SYNC_W-1:0] s_bat_q, s_fail_q, s_warn_q;
  logic                   bat_ok_q, fail_ok_q, warn_ok_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_bat_q   <= '0;
      s_fail_q  <= '0;
      s_warn_q  <= '0;
      bat_ok_q  <= 1'b0;
      fail_ok_q <= 1'b0;
      warn_ok_q <= 1'b0;
    end else begin
      s_bat_q  <= {s_bat_q[`RSS_SYNC_W-2:0], bat_above_por};
      s_fail_q <= {s_fail_q[`RSS_SYNC_W-2:0], vdd_above_fail};
      s_warn_q <= {s_warn_q[`RSS_SYNC_W-2:0], vdd_above_warn};
      if (s_bat_q[1] == s_bat_q[2])
        bat_ok_q <= s_bat_q[2];
      if (s_fail_q[1] == s_fail_q[2])
        fail_ok_q <= s_fail_q[2];
      if (s_warn_q[1] == s_warn_q[2])
        warn_ok_q <= s_warn_q[2];
    end
  end

  rss_pkg::rss_state_t  st_q, st_d;
  logic [31:0]          cnt_q, cnt_d;
  logic                 por_q, por_d;
  logic                 pin_q, pin_d;
  rss_pkg::rss_mon_cfg_t cfg_q, cfg_d;
  logic                 battery_monitor_disable_q, battery_monitor_disable_d;
  logic                 flag_q, flag_d;
  logic                 ferr_q, ferr_d;
  logic                 fok_q, fok_d;
  logic                 pf_trip, any_soft_rst;

  always_comb begin
    pf_trip      = cfg_q.supply_monitor_enable && cfg_q.monitor_select && !sleep_mode && !fail_ok_q;
    any_soft_rst = other_rst_req || ferr_q;
    st_d     = st_q;
    cnt_d    = cnt_q;
    por_d    = por_q;
    pin_d    = pin_q;
    cfg_d    = cfg_q;
    battery_monitor_disable_d = battery_monitor_disable_q;
    flag_d   = flag_q;
    ferr_d   = 1'b0;
    fok_d    = 1'b0;
    if (st_q == rss_pkg::RSS_ST_RUN) begin
      if (mon_ctl_wr)
        cfg_d.supply_monitor_enable = mon_ctl_wr_enable;
      if (cause_wr)
        cfg_d.monitor_select = cause_wr_poweron_bit;
      if (mode_wr)
        battery_monitor_disable_d = mode_wr_battery_monitor_disable;
      if (flash_op_req) begin
        ferr_d = !cfg_q.supply_monitor_enable;
        fok_d  = cfg_q.supply_monitor_enable;
      end
    end
    case (st_q)
      rss_pkg::RSS_ST_HOLD: begin
        pin_d = por_q || pf_trip;
        if (por_q) begin
          if (bat_ok_q) begin
            st_d  = rss_pkg::RSS_ST_PORWAIT;
            cnt_d = '0;
          end
        end else if (fail_ok_q || !pf_trip) begin
          st_d  = rss_pkg::RSS_ST_RUN;
          pin_d = 1'b0;
        end
      end
      rss_pkg::RSS_ST_PORWAIT: begin
        cnt_d = cnt_q + 32'h1;
        if (!bat_ok_q) begin
          st_d = rss_pkg::RSS_ST_HOLD;
        end else if ((bat_level == rss_pkg::RSS_LVL_LOW && cnt_q >= CYC_LO - 1) ||
                     (bat_level == rss_pkg::RSS_LVL_MID && cnt_q >= CYC_MID - 1) ||
                     (cnt_q >= CYC_HI - 1)) begin
          st_d  = rss_pkg::RSS_ST_RUN;
          pin_d = 1'b0;
          por_d = 1'b0;
          flag_d = 1'b1;
        end
      end
      rss_pkg::RSS_ST_RUN: begin
        if (!bat_ok_q || (any_soft_rst && battery_monitor_disable_q)) begin
          st_d     = rss_pkg::RSS_ST_HOLD;
          por_d    = 1'b1;
          pin_d    = 1'b1;
          battery_monitor_disable_d = 1'b0;
          cfg_d    = '{1'b1, 1'b1};
        end else if (pf_trip) begin
          st_d   = rss_pkg::RSS_ST_HOLD;
          pin_d  = 1'b1;
          cfg_d  = '{1'b1, 1'b1};
          flag_d = 1'b1;
        end else if (any_soft_rst) begin
          st_d   = rss_pkg::RSS_ST_HOLD;
          flag_d = 1'b0;
        end
      end
      default: st_d = rss_pkg::RSS_ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= rss_pkg::RSS_ST_HOLD;
      cnt_q    <= '0;
      por_q    <= 1'b1;
      pin_q    <= 1'b1;
      cfg_q    <= '{1'b1, 1'b1};
      battery_monitor_disable_q <= 1'b0;
      flag_q   <= 1'b1;
      ferr_q   <= 1'b0;
      fok_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      por_q    <= por_d;
      pin_q    <= pin_d;
      cfg_q    <= cfg_d;
      battery_monitor_disable_q <= battery_monitor_disable_d;
      flag_q   <= flag_d;
      ferr_q   <= ferr_d;
      fok_q    <= fok_d;
    end
  end

  // core control and watchdog prescaler
  logic                   hold_d, run_d;
  logic [3:0]             wdiv_q, wdiv_d;
  logic                   wtick_q, wtick_d;
  rss_pkg::rss_core_ctl_t ctl_q, ctl_d;
  logic                   ew_q, ew_d, ewirq_q, ewirq_d;
  always_comb begin
    hold_d = (st_d != rss_pkg::RSS_ST_RUN);
    run_d  = !hold_d;
    ctl_d.core_rst    = hold_d;
    ctl_d.rst_pin_oe  = pin_d;
    ctl_d.port_latch  = `RSS_PORT_RST;
    ctl_d.pullup_en   = 1'b1;
    ctl_d.irq_tmr_dis = hold_d;
    ctl_d.sp_rst      = hold_d;
    ctl_d.pc_load     = `RSS_PC_RST;
    ctl_d.int_osc_sel = 1'b1;
    ctl_d.wdt_run     = run_d;
    wdiv_d  = wdiv_q;
    wtick_d = 1'b0;
    if (!run_d) begin
      wdiv_d = 4'h0;
    end else if (wdiv_q == `RSS_WDT_DIV) begin
      wdiv_d  = 4'h0;
      wtick_d = 1'b1;
    end else begin
      wdiv_d = wdiv_q + 4'h1;
    end
    ew_d    = warn_ok_q;
    ewirq_d = ewirq_q;
    if (ew_q && !warn_ok_q && early_ok_ie)
      ewirq_d = 1'b1;
    else if (warn_ok_q)
      ewirq_d = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q   <= '{1'b1, 1'b1, 8'hff, 1'b1, 1'b1, 1'b1, 16'h0000, 1'b1, 1'b0};
      wdiv_q  <= 4'h0;
      wtick_q <= 1'b0;
      ew_q    <= 1'b0;
      ewirq_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      wdiv_q  <= wdiv_d;
      wtick_q <= wtick_d;
      ew_q    <= ew_d;
      ewirq_q <= ewirq_d;
    end
  end

  assign rst_pin_o               = 1'b0;
  assign rst_pin_oe              = pin_q;
  assign core_ctl                = ctl_q;
  assign wdt_tick                = wtick_q;
  assign poweron_flag            = flag_q;
  assign mon_cfg                 = cfg_q;
  assign battery_monitor_disable = battery_monitor_disable_q;
  assign supply_early_ok         = ew_q;
  assign early_warn_irq          = ewirq_q;
  assign flash_op_ok             = fok_q;
  assign flash_error_rst         = ferr_q;

  // watchdog tick spacing, counted for the check below
  logic [3:0] wgap_q, wgap_d;
  logic       wseen_q, wseen_d;
  always_comb begin
    wgap_d  = wgap_q + 4'h1;
    wseen_d = wseen_q;
    if (!core_ctl.wdt_run) begin
      wgap_d  = 4'h0;
      wseen_d = 1'b0;
    end else if (wdt_tick) begin
      wgap_d  = 4'h0;
      wseen_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wgap_q  <= 4'h0;
      wseen_q <= 1'b0;
    end else begin
      wgap_q  <= wgap_d;
      wseen_q <= wseen_d;
    end
  end

  // checks
  property p_hold_core;
    @(posedge clk) disable iff (!nrst) (st_q != rss_pkg::RSS_ST_RUN) |-> core_ctl.core_rst;
  endproperty
  a_hold_core: assert property (p_hold_core) else $error("core not held");
  property p_por_pin;
    @(posedge clk) disable iff (!nrst) por_q |-> pin_q;
  endproperty
  a_por_pin: assert property (p_por_pin) else $error("pin not low in por");
  property p_flag_por;
    @(posedge clk) disable iff (!nrst)
      (st_q == rss_pkg::RSS_ST_PORWAIT && st_d == rss_pkg::RSS_ST_RUN) |=> poweron_flag;
  endproperty
  a_flag_por: assert property (p_flag_por) else $error("flag not set");
  property p_pf_cfg;
    @(posedge clk) disable iff (!nrst) (st_q == rss_pkg::RSS_ST_RUN && pf_trip && bat_ok_q && !(any_soft_rst && battery_monitor_disable_q))
      |=> mon_cfg == 2'b11 && poweron_flag && rst_pin_oe;
  endproperty
  a_pf_cfg: assert property (p_pf_cfg) else $error("power-fail effects wrong");
  property p_soft_keep;
    @(posedge clk) disable iff (!nrst) (st_q == rss_pkg::RSS_ST_RUN && other_rst_req && !battery_monitor_disable_q && !pf_trip && bat_ok_q
      && !mon_ctl_wr && !cause_wr)
      |=> $stable(mon_cfg) && !poweron_flag;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset touched monitor");
  property p_ferr;
    @(posedge clk) disable iff (!nrst) (st_q == rss_pkg::RSS_ST_RUN && flash_op_req && !mon_cfg.supply_monitor_enable)
      |=> flash_error_rst && !flash_op_ok;
  endproperty
  a_ferr: assert property (p_ferr) else $error("flash error missed");
  property p_wdt;
    @(posedge clk) disable iff (!nrst) (core_ctl.wdt_run && wseen_q) |-> (wdt_tick == (wgap_q == `RSS_WDT_DIV));
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog divide wrong");
  property p_sleep;
    @(posedge clk) disable iff (!nrst) (sleep_mode && st_q == rss_pkg::RSS_ST_RUN && bat_ok_q && !any_soft_rst)
      |=> st_q == rss_pkg::RSS_ST_RUN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("reset in sleep");
  c_por: cover property (@(posedge clk) disable iff (!nrst) st_q == rss_pkg::RSS_ST_PORWAIT ##1 st_q == rss_pkg::RSS_ST_RUN);
  c_pf: cover property (@(posedge clk) disable iff (!nrst) st_q == rss_pkg::RSS_ST_RUN && pf_trip);
  c_ferr: cover property (@(posedge clk) disable iff (!nrst) flash_error_rst);
endmodule
`default_nettype wire

// ---- verif/rss_supply_model.sv ----
// analog supply comparators and reset pin pull-up facing the sequencer
// assumes supply levels in millivolts driven by the bench at the falling edge
`timescale 1ns/1ps
`default_nettype none
module rss_supply_model #(
  parameter int POR_MV  = 800,
  parameter int FAIL_MV = 1700,
  parameter int WARN_MV = 1800
) (
  input  wire logic [11:0]    bat_mv,
  input  wire logic [11:0]    vdd_mv,
  input  wire logic           rst_pin_o,
  input  wire logic           rst_pin_oe,
  output logic                bat_above_por,
  output logic                vdd_above_fail,
  output logic                vdd_above_warn,
  output rss_pkg::rss_level_t bat_level,
  output logic                rst_pin_level
);
  assign bat_above_por  = int'(bat_mv) > POR_MV;
  assign vdd_above_fail = int'(vdd_mv) > FAIL_MV;
  assign vdd_above_warn = int'(vdd_mv) > WARN_MV;
  always_comb begin
    if (bat_mv < 12'h546) begin
      bat_level = rss_pkg::RSS_LVL_LOW;
    end else if (bat_mv < 12'ha8c) begin
      bat_level = rss_pkg::RSS_LVL_MID;
    end else begin
      bat_level = rss_pkg::RSS_LVL_HIGH;
    end
  end
  // released pin floats to its pull-up
  assign rst_pin_level = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule
`default_nettype wire

// ---- verif/tb_reset_source_sequencer.sv ----
// self-checking bench for the reset source sequencer
// assumes the supply model drives comparators; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_sequencer;
  localparam int POR_LO = 3 * 25000;
  logic clk = 1'b0, nrst = 1'b0, sleep_mode = 1'b0, other_rst_req = 1'b0, flash_op_req = 1'b0;
  logic cause_wr = 1'b0, cause_wr_poweron_bit = 1'b0, mon_ctl_wr = 1'b0, mon_ctl_wr_enable = 1'b0;
  logic mode_wr = 1'b0, mode_wr_battery_monitor_disable = 1'b0, early_ok_ie = 1'b1;
  logic [11:0] bat_mv = 12'h000, vdd_mv = 12'hbb8;
  logic bat_above_por, vdd_above_fail, vdd_above_warn, rst_pin_o, rst_pin_oe, pin, wdt_tick, poweron_flag;
  logic battery_monitor_disable, supply_early_ok, early_warn_irq, flash_op_ok, flash_error_rst;
  rss_pkg::rss_level_t    bat_level;
  rss_pkg::rss_core_ctl_t core_ctl;
  rss_pkg::rss_mon_cfg_t  mon_cfg;
  int num_errors = 0, num_checks = 0, cyc = 0, n;
  always #20 clk = ~clk;
  rss_supply_model PM (.bat_mv(bat_mv), .vdd_mv(vdd_mv), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .bat_above_por(bat_above_por), .vdd_above_fail(vdd_above_fail), .vdd_above_warn(vdd_above_warn),
    .bat_level(bat_level), .rst_pin_level(pin));
  rss_reset_source_sequencer DUT (.clk(clk), .nrst(nrst), .bat_above_por(bat_above_por),
    .vdd_above_fail(vdd_above_fail), .vdd_above_warn(vdd_above_warn), .bat_level(bat_level),
    .sleep_mode(sleep_mode), .other_rst_req(other_rst_req), .flash_op_req(flash_op_req), .cause_wr(cause_wr),
    .cause_wr_poweron_bit(cause_wr_poweron_bit), .mon_ctl_wr(mon_ctl_wr), .mon_ctl_wr_enable(mon_ctl_wr_enable),
    .mode_wr(mode_wr), .mode_wr_battery_monitor_disable(mode_wr_battery_monitor_disable),
    .early_ok_ie(early_ok_ie), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .core_ctl(core_ctl),
    .wdt_tick(wdt_tick), .poweron_flag(poweron_flag), .mon_cfg(mon_cfg),
    .battery_monitor_disable(battery_monitor_disable), .supply_early_ok(supply_early_ok),
    .early_warn_irq(early_warn_irq), .flash_op_ok(flash_op_ok), .flash_error_rst(flash_error_rst));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one-cycle strobe: 0 monitor enable, 1 cause select, 2 mode, 3 other reset, 4 flash op
  task automatic pulse(input int k, input logic b);
    @(negedge clk);
    case (k)
      0: begin mon_ctl_wr = 1'b1; mon_ctl_wr_enable = b; end
      1: begin cause_wr = 1'b1; cause_wr_poweron_bit = b; end
      2: begin mode_wr = 1'b1; mode_wr_battery_monitor_disable = b; end
      3: other_rst_req = 1'b1;
      default: flash_op_req = 1'b1;
    endcase
    @(negedge clk);
    {mon_ctl_wr, cause_wr, mode_wr, other_rst_req, flash_op_req} = 5'h00;
  endtask
  task automatic wait_core(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (core_ctl.core_rst !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    settle(2);
    check("pin_held", pin, 1'b0);
    check("core_held", {core_ctl.core_rst, core_ctl.irq_tmr_dis, core_ctl.sp_rst}, 3'h7);
    check("ports", {core_ctl.port_latch, core_ctl.pullup_en}, 9'h1ff);
    check("flag_por", poweron_flag, 1'b1);
    nrst = 1'b1;
    settle(20);
    check("hold_low_bat", {core_ctl.core_rst, pin}, 2'h2);
    bat_mv = 12'h3e8;
    wait_core(1'b0, POR_LO + 100, n);
    check("por_delay", n >= POR_LO && n <= POR_LO + 10, 1'b1);
    check("exit", {pin, core_ctl.pc_load, core_ctl.int_osc_sel, core_ctl.wdt_run}, 19'h40003);
    check("pullup_after", core_ctl.pullup_en, 1'b1);
    check("cfg_por", mon_cfg, 2'h3);
    $display("test por done");
    n = 0;
    while (wdt_tick !== 1'b1 && n < 30) begin settle(1); n++; end
    n = 0;
    do begin settle(1); n++; end while (wdt_tick !== 1'b1 && n < 30);
    check("wdt_period", n, 12);
    vdd_mv = 12'h6d6;
    settle(8);
    check("warn", {supply_early_ok, early_warn_irq, core_ctl.core_rst}, 3'h2);
    vdd_mv = 12'hbb8;
    settle(8);
    check("warn_gone", {supply_early_ok, early_warn_irq}, 2'h2);
    pulse(4, 1'b0);
    check("flash_ok", {flash_op_ok, flash_error_rst}, 2'h2);
    $display("test warn and flash done");
    pulse(1, 1'b0);
    pulse(0, 1'b0);
    pulse(3, 1'b0);
    settle(10);
    check("soft_rst", {poweron_flag, mon_cfg, core_ctl.core_rst}, 4'h0);
    pulse(4, 1'b0);
    check("flash_err", {flash_op_ok, flash_error_rst}, 2'h1);
    settle(10);
    check("ferr_cfg", {mon_cfg, poweron_flag}, 3'h0);
    pulse(0, 1'b1);
    pulse(1, 1'b1);
    check("cfg_sel", mon_cfg, 2'h3);
    $display("test soft reset done");
    sleep_mode = 1'b1;
    early_ok_ie = 1'b0;
    vdd_mv = 12'h5dc;
    settle(10);
    check("sleep_nofail", {core_ctl.core_rst, pin}, 2'h1);
    check("warn_masked", {supply_early_ok, early_warn_irq}, 2'h0);
    early_ok_ie = 1'b1;
    vdd_mv = 12'hbb8;
    settle(8);
    sleep_mode = 1'b0;
    settle(2);
    check("wake_cfg", mon_cfg, 2'h3);
    vdd_mv = 12'h5dc;
    wait_core(1'b1, 10, n);
    check("pf_enter", {core_ctl.core_rst, pin, poweron_flag}, 3'h5);
    check("pf_cfg", mon_cfg, 2'h3);
    vdd_mv = 12'hbb8;
    wait_core(1'b0, 20, n);
    check("pf_nodelay", n <= 8, 1'b1);
    $display("test sleep and power fail done");
    pulse(1, 1'b0);
    pulse(0, 1'b0);
    pulse(2, 1'b1);
    check("bmd_set", battery_monitor_disable, 1'b1);
    pulse(3, 1'b0);
    settle(6);
    check("full_por", {core_ctl.core_rst, pin, poweron_flag, battery_monitor_disable}, 4'ha);
    check("full_por_cfg", mon_cfg, 2'h3);
    $display("test battery monitor off done");
    conclude();
  end
endmodule
`default_nettype wire
